/* include/sxh_defines.vh */
// Constants for the exclusive and halfword store execute block.
`ifndef SXH_DEFINES_VH
`define SXH_DEFINES_VH

// ****************************************
// Register numbers
// ****************************************
`define SXH_REG_SP 4'hd
`define SXH_REG_PC 4'hf

// ****************************************
// Opcode fields
// ****************************************
`define SXH_OP_STORE_HALFWORD_SHORT 5'h10
`define SXH_OP_EXCL_WORD 12'he84
`define SXH_OP_EXCL_BH 12'he8c
`define SXH_OP_EXCL_BH_LOW 7'h7a
`define SXH_OP_STORE_HALFWORD_LONG 12'hf8a
`define SXH_OP_STORE_HALFWORD_BYTE 12'hf82

// ****************************************
// Instruction kinds
// ****************************************
`define SXH_KIND_EXCL_WORD 2'h0
`define SXH_KIND_EXCL_BYTE 2'h1
`define SXH_KIND_EXCL_HALF 2'h2
`define SXH_KIND_STORE_HALFWORD 2'h3

// ****************************************
// Access sizes in bytes and status values
// ****************************************
`define SXH_SIZE_BYTE 3'h1
`define SXH_SIZE_HALF 3'h2
`define SXH_SIZE_WORD 3'h4
`define SXH_STATUS_PASS 32'h00000000
`define SXH_STATUS_FAIL 32'h00000001

`endif

/* rtl/sxh_regfile.v */
// Sixteen-entry general register file with two registered read ports.
`timescale 1ns/1ns
`default_nettype none

module sxh_regfile (
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [3:0] wr_idx,
  input wire [31:0] wr_data,
  // Read ports
  input wire rd_en,
  input wire [3:0] rd_a_idx,
  input wire [3:0] rd_b_idx,
  output reg [31:0] rd_a_data,
  output reg [31:0] rd_b_data
);

  reg [31:0] mem [0:15];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always @(posedge clk) begin
    if (rd_en) begin
      rd_a_data <= mem[rd_a_idx];
      rd_b_data <= mem[rd_b_idx];
    end
  end

endmodule

`default_nettype wire

/* rtl/sxh_store_exec.v */
// Decode and execute of exclusive stores and immediate halfword stores.
`timescale 1ns/1ns
`default_nettype none
`include "sxh_defines.vh"

module sxh_store_exec (
  // Clock and reset
  input wire CLOCK,
  input wire SYS_RST,
  // Instruction issue
  input wire INSTR_VALID,
  input wire INSTR_WIDE,
  input wire [31:0] INSTR,
  input wire MAIN_EXT,
  output wire BUSY,
  // Register preload
  input wire LOAD_EN,
  input wire [3:0] LOAD_IDX,
  input wire [31:0] LOAD_DATA,
  // Stack limit
  input wire [31:0] SP_LIMIT,
  // Exclusive monitor
  output wire MON_REQ,
  output reg [31:0] MON_ADDR,
  output reg [2:0] MON_SIZE,
  input wire MON_ACK,
  input wire MON_PASS,
  // Memory write
  output wire MEM_REQ,
  output reg [31:0] MEM_ADDR,
  output reg [31:0] MEM_DATA,
  output reg [2:0] MEM_SIZE,
  input wire MEM_ACK,
  // Register writeback
  output reg WB_EN,
  output reg [3:0] WB_IDX,
  output reg [31:0] WB_DATA,
  // Outcome pulses
  output reg DONE,
  output reg UNDEF,
  output reg REDIRECT_UNPRIV,
  output reg NOT_MINE,
  output reg SP_FAULT
);

  // ****************************************
  // States
  // ****************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_READ = 5'h02;
  localparam [4:0] ST_MON = 5'h04;
  localparam [4:0] ST_MEM = 5'h08;
  localparam [4:0] ST_WB = 5'h10;

  reg [4:0] state, next_state;

  // ****************************************
  // Decode helpers
  // ****************************************
  function is_sp_pc;
    input [3:0] r;
    begin
      is_sp_pc = (r == `SXH_REG_SP) || (r == `SXH_REG_PC);
    end
  endfunction

  function is_pc;
    input [3:0] r;
    begin
      is_pc = (r == `SXH_REG_PC);
    end
  endfunction

  // ****************************************
  // Combinational decode
  // ****************************************
  wire [15:0] hw1 = INSTR[31:16];
  wire [15:0] hw2 = INSTR[15:0];
  wire bit_p = hw2[10];
  wire bit_u = hw2[9];
  wire bit_w = hw2[8];

  reg [1:0] next_kind;
  reg [3:0] next_n, next_t, next_d;
  reg [11:0] next_imm;
  reg next_index, next_add, next_wback;
  reg dec_match, dec_redirect, dec_undef;

  always @* begin
    next_kind = `SXH_KIND_STORE_HALFWORD;
    next_n = 4'h0;
    next_t = 4'h0;
    next_d = 4'h0;
    next_imm = 12'h000;
    next_index = 1'b1;
    next_add = 1'b1;
    next_wback = 1'b0;
    dec_match = 1'b0;
    dec_redirect = 1'b0;
    dec_undef = 1'b0;
    if (!INSTR_WIDE) begin
      if (hw2[15:11] == `SXH_OP_STORE_HALFWORD_SHORT) begin
        dec_match = 1'b1;
        next_imm = {6'h00, hw2[10:6], 1'b0};
        next_n = {1'b0, hw2[5:3]};
        next_t = {1'b0, hw2[2:0]};
      end
    end else begin
      next_n = hw1[3:0];
      next_t = hw2[15:12];
      case (hw1[15:4])
        `SXH_OP_EXCL_WORD: begin
          next_kind = `SXH_KIND_EXCL_WORD;
          next_d = hw2[11:8];
          next_imm = {2'b00, hw2[7:0], 2'b00};
          dec_match = !is_pc(next_t);
          dec_undef = is_sp_pc(next_d) || (next_t == `SXH_REG_SP) || is_pc(next_n) ||
                      (next_d == next_n) || (next_d == next_t);
        end
        `SXH_OP_EXCL_BH: begin
          next_kind = hw2[4] ? `SXH_KIND_EXCL_HALF : `SXH_KIND_EXCL_BYTE;
          next_d = hw2[3:0];
          dec_match = (hw2[11:5] == `SXH_OP_EXCL_BH_LOW);
          dec_undef = is_sp_pc(next_d) || is_sp_pc(next_t) || is_pc(next_n) ||
                      (next_d == next_t) || (next_d == next_n);
        end
        `SXH_OP_STORE_HALFWORD_LONG: begin
          dec_match = 1'b1;
          next_imm = hw2[11:0];
          dec_undef = is_pc(next_n) || !MAIN_EXT || is_sp_pc(next_t);
        end
        `SXH_OP_STORE_HALFWORD_BYTE: begin
          dec_match = hw2[11];
          next_imm = {4'h0, hw2[7:0]};
          next_index = bit_p;
          next_add = bit_u;
          next_wback = bit_w;
          if (bit_p && bit_u && !bit_w) begin
            dec_redirect = 1'b1;
          end else begin
            dec_undef = is_pc(next_n) || (!bit_p && !bit_w) ||
                        !MAIN_EXT || is_sp_pc(next_t) ||
                        (bit_w && (next_n == next_t));
          end
        end
        default: dec_match = 1'b0;
      endcase
    end
  end

  wire accept = state[0] && INSTR_VALID;
  wire go = accept && dec_match && !dec_redirect && !dec_undef;

  // ****************************************
  // Latched instruction
  // ****************************************
  reg [1:0] kind;
  reg [3:0] reg_n, reg_d;
  reg [11:0] imm;
  reg index, add, wback;
  reg [31:0] offset_addr;

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      kind <= `SXH_KIND_STORE_HALFWORD;
      reg_n <= 4'h0;
      reg_d <= 4'h0;
      imm <= 12'h000;
      index <= 1'b1;
      add <= 1'b1;
      wback <= 1'b0;
    end else if (go) begin
      kind <= next_kind;
      reg_n <= next_n;
      reg_d <= next_d;
      imm <= next_imm;
      index <= next_index;
      add <= next_add;
      wback <= next_wback;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  wire [31:0] base_val, src_val;
  reg rf_wr_en;
  reg [3:0] rf_wr_idx;
  reg [31:0] rf_wr_data;

  // The preload port only wins while no instruction is in flight.
  always @* begin
    rf_wr_en = WB_EN;
    rf_wr_idx = WB_IDX;
    rf_wr_data = WB_DATA;
    if (!WB_EN && LOAD_EN && state[0]) begin
      rf_wr_en = 1'b1;
      rf_wr_idx = LOAD_IDX;
      rf_wr_data = LOAD_DATA;
    end
  end

  sxh_regfile u_regfile (
    .clk(CLOCK),
    .wr_en(rf_wr_en),
    .wr_idx(rf_wr_idx),
    .wr_data(rf_wr_data),
    .rd_en(go),
    .rd_a_idx(next_n),
    .rd_b_idx(next_t),
    .rd_a_data(base_val),
    .rd_b_data(src_val)
  );

  // ****************************************
  // Address and limit
  // ****************************************
  wire is_excl = (kind != `SXH_KIND_STORE_HALFWORD);
  wire [31:0] imm32 = {20'h00000, imm};
  wire [31:0] calc_offset = add ? base_val + imm32 : base_val - imm32;
  wire [31:0] calc_addr = index ? calc_offset : base_val;
  wire apply_limit = (reg_n == `SXH_REG_SP) && wback;
  wire limit_ok = !apply_limit || (calc_offset >= SP_LIMIT);

  reg [2:0] size_sel;
  reg [31:0] data_sel;

  always @* begin
    size_sel = `SXH_SIZE_HALF;
    data_sel = {16'h0000, src_val[15:0]};
    case (kind)
      `SXH_KIND_EXCL_WORD: begin
        size_sel = `SXH_SIZE_WORD;
        data_sel = src_val;
      end
      `SXH_KIND_EXCL_BYTE: begin
        size_sel = `SXH_SIZE_BYTE;
        data_sel = {24'h000000, src_val[7:0]};
      end
      default: size_sel = `SXH_SIZE_HALF;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign BUSY = !state[0];
  assign MON_REQ = state[2];
  assign MEM_REQ = state[3];

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = go ? ST_READ : ST_IDLE;
      ST_READ: next_state = is_excl ? ST_MON : (limit_ok ? ST_MEM : ST_IDLE);
      ST_MON: next_state = MON_ACK ? (MON_PASS ? ST_MEM : ST_WB) : ST_MON;
      ST_MEM: next_state = MEM_ACK ? ((is_excl || wback) ? ST_WB : ST_IDLE) : ST_MEM;
      ST_WB: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Data path registers
  // ****************************************
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      MON_ADDR <= 32'h00000000;
      MON_SIZE <= `SXH_SIZE_WORD;
      MEM_ADDR <= 32'h00000000;
      MEM_DATA <= 32'h00000000;
      MEM_SIZE <= `SXH_SIZE_WORD;
      offset_addr <= 32'h00000000;
    end else if (state[1]) begin
      MON_ADDR <= calc_addr;
      MON_SIZE <= size_sel;
      MEM_ADDR <= calc_addr;
      MEM_DATA <= data_sel;
      MEM_SIZE <= size_sel;
      offset_addr <= calc_offset;
    end
  end

  // Writeback is held one cycle so the regfile and the port agree.
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      WB_EN <= 1'b0;
      WB_IDX <= 4'h0;
      WB_DATA <= 32'h00000000;
    end else begin
      WB_EN <= 1'b0;
      if (state[2] && MON_ACK && !MON_PASS) begin
        WB_EN <= 1'b1;
        WB_IDX <= reg_d;
        WB_DATA <= `SXH_STATUS_FAIL;
      end else if (state[3] && MEM_ACK && is_excl) begin
        WB_EN <= 1'b1;
        WB_IDX <= reg_d;
        WB_DATA <= `SXH_STATUS_PASS;
      end else if (state[3] && MEM_ACK && wback) begin
        WB_EN <= 1'b1;
        WB_IDX <= reg_n;
        WB_DATA <= offset_addr;
      end
    end
  end

  // ****************************************
  // Outcome pulses
  // ****************************************
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      DONE <= 1'b0;
      UNDEF <= 1'b0;
      REDIRECT_UNPRIV <= 1'b0;
      NOT_MINE <= 1'b0;
      SP_FAULT <= 1'b0;
    end else begin
      DONE <= (state[4]) || (state[3] && MEM_ACK && !is_excl && !wback) ||
              (state[1] && !is_excl && !limit_ok);
      UNDEF <= accept && dec_match && !dec_redirect && dec_undef;
      REDIRECT_UNPRIV <= accept && dec_match && dec_redirect;
      NOT_MINE <= accept && !dec_match;
      SP_FAULT <= state[1] && !is_excl && !limit_ok;
    end
  end

endmodule

`default_nettype wire

/* test/sxh_mem_model.sv */
// Behavioural memory system with exclusive monitor answers.
`timescale 1ns/1ns
`default_nettype none

module sxh_mem_model (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Requests
  input wire logic MON_REQ,
  input wire logic MEM_REQ,
  // Answers
  output logic MON_ACK,
  output logic MON_PASS,
  output logic MEM_ACK,
  // Bench controls
  input wire logic pass_en,
  input wire logic [1:0] dly
);
  logic [1:0] wait_cnt;

  // Answers come late by a varying count so that the core must hold its request.
  // The verdict line toggles outside an answer, so a stale sample is not a lucky match.
  always @(posedge CLOCK) begin
    MON_ACK <= 1'b0;
    MEM_ACK <= 1'b0;
    MON_PASS <= ~MON_PASS;
    if (SYS_RST) begin
      wait_cnt <= 2'h0;
      MON_PASS <= 1'b0;
    end else if ((MON_REQ && !MON_ACK) || (MEM_REQ && !MEM_ACK)) begin
      if (wait_cnt == 2'h0) begin
        MON_ACK <= MON_REQ;
        MON_PASS <= pass_en;
        MEM_ACK <= MEM_REQ;
        wait_cnt <= dly;
      end else
        wait_cnt <= wait_cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* test/sxh_store_exec_asserts.sv */
// Port checks for the exclusive and halfword store execute block.
`timescale 1ns/1ns
`default_nettype none

module sxh_store_exec_asserts (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Issue
  input wire logic INSTR_VALID,
  input wire logic INSTR_WIDE,
  input wire logic [31:0] INSTR,
  input wire logic MAIN_EXT,
  input wire logic BUSY,
  // Monitor and memory
  input wire logic MON_REQ,
  input wire logic [31:0] MON_ADDR,
  input wire logic [2:0] MON_SIZE,
  input wire logic MON_ACK,
  input wire logic MON_PASS,
  input wire logic MEM_REQ,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_DATA,
  input wire logic [2:0] MEM_SIZE,
  input wire logic MEM_ACK,
  // Outcomes
  input wire logic WB_EN,
  input wire logic [31:0] WB_DATA,
  input wire logic DONE,
  input wire logic UNDEF,
  input wire logic REDIRECT_UNPRIV,
  input wire logic SP_FAULT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Issue checks look only at wide instructions that the block really takes.
  wire take = INSTR_VALID && !BUSY && INSTR_WIDE;

  mon_hold_a: assert property (MON_REQ && !MON_ACK |=> MON_REQ && $stable(MON_ADDR) && $stable(MON_SIZE))
    else $error("monitor request dropped or changed");
  pass_write_a: assert property (MON_REQ && MON_ACK && MON_PASS |=>
    MEM_REQ && MEM_ADDR == $past(MON_ADDR) && MEM_SIZE == $past(MON_SIZE))
    else $error("passed exclusive not written");
  fail_status_a: assert property (MON_REQ && MON_ACK && !MON_PASS |=>
    !MEM_REQ && WB_EN && WB_DATA == 32'h1 ##1 DONE)
    else $error("failed exclusive status wrong");
  mem_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_DATA))
    else $error("write request dropped or changed");
  wb_done_a: assert property (WB_EN |=> DONE && !BUSY)
    else $error("writeback not followed by done");
  fault_skip_a: assert property (SP_FAULT |-> DONE && !MEM_REQ && !WB_EN)
    else $error("stack fault with side effects");
  ext_undef_a: assert property (take && !MAIN_EXT && INSTR[31:20] == 12'hf8a |=> UNDEF)
    else $error("wide store without extension not undefined");
  unpriv_redirect_a: assert property (take && MAIN_EXT && INSTR[31:20] == 12'hf82 && INSTR[11:8] == 4'he |=>
    REDIRECT_UNPRIV)
    else $error("unprivileged form not redirected");
endmodule

bind sxh_store_exec sxh_store_exec_asserts chk (.*);
`default_nettype wire

/* test/sxh_store_exec_bench.sv */
// Self-checking bench for the exclusive and halfword store execute block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end \
  end

module sxh_store_exec_bench;
  // ********
  // Signals
  // ********
  logic CLOCK = 0;
  logic SYS_RST = 1;
  logic INSTR_VALID = 0;
  logic INSTR_WIDE = 0;
  logic MAIN_EXT = 1;
  logic LOAD_EN = 0;
  logic [3:0] LOAD_IDX = 0;
  logic [31:0] INSTR = 0, LOAD_DATA = 0, SP_LIMIT = 0;
  logic pass_en = 1;
  logic [1:0] dly = 0;
  wire MON_REQ, MON_ACK, MON_PASS, MEM_REQ, MEM_ACK, BUSY, WB_EN;
  wire DONE, UNDEF, REDIRECT_UNPRIV, NOT_MINE, SP_FAULT;
  wire [31:0] MON_ADDR, MEM_ADDR, MEM_DATA, WB_DATA;
  wire [2:0] MON_SIZE, MEM_SIZE;
  wire [3:0] WB_IDX;
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] rf [16];
  logic [31:0] ga, gd, gwd, ea, ed, ewd, off, gma;
  logic [2:0] gs, es, gms;
  logic [3:0] gwi, ewi;
  logic [7:0] im;
  logic gm, gw, em, ew;
  logic [2:0] puw [5] = '{3'b100, 3'b001, 3'b011, 3'b101, 3'b111};
  logic [31:0] bad [11] = '{32'he8c1df43, 32'he8c12f52, 32'he8c12f41, 32'he8412100, 32'he8412200,
    32'he8cf2f43, 32'hf82f7d04, 32'hf8267a04, 32'hf8266d04, 32'hf8a4f000, 32'he8412d00};

  sxh_store_exec dut (.*);
  sxh_mem_model far (.*);

  initial begin
    forever #4 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    if (MEM_REQ && MEM_ACK) begin
      gm <= 1;
      ga <= MEM_ADDR;
      gd <= MEM_DATA;
      gs <= MEM_SIZE;
    end
    if (MON_REQ && MON_ACK) begin
      gma <= MON_ADDR;
      gms <= MON_SIZE;
    end
    if (WB_EN) begin
      gw <= 1;
      gwi <= WB_IDX;
      gwd <= WB_DATA;
    end
  end

  task automatic summarize;
    begin
      if (err_count == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task automatic want(input logic m, input logic [31:0] a, d, input logic [2:0] s, input logic w,
    input logic [3:0] wi, input logic [31:0] wd);
    begin
      em = m;
      ea = a;
      ed = d;
      es = s;
      ew = w;
      ewi = wi;
      ewd = wd;
    end
  endtask

  task automatic ld(input logic [3:0] i, input logic [31:0] v);
    begin
      @(posedge CLOCK);
      LOAD_EN <= 1;
      LOAD_IDX <= i;
      LOAD_DATA <= v;
      @(posedge CLOCK);
      LOAD_EN <= 0;
      rf[i] = v;
    end
  endtask

  // Pulses are read just after the edge, so the value seen is the one the edge sampled.
  task automatic run(input logic [31:0] ins, input logic w, input logic [4:0] ek);
    int n;
    begin
      gm = 0;
      gw = 0;
      gms = 0;
      n = 0;
      @(posedge CLOCK);
      dly <= $urandom % 4;
      INSTR <= ins;
      INSTR_WIDE <= w;
      INSTR_VALID <= 1;
      @(posedge CLOCK);
      INSTR_VALID <= 0;
      while (n < 60 && !(UNDEF || REDIRECT_UNPRIV || NOT_MINE || DONE)) begin
        @(posedge CLOCK);
        n++;
      end
      if (n == 60) begin
        err_count++;
        summarize();
      end
      `CHK({UNDEF, REDIRECT_UNPRIV, NOT_MINE, SP_FAULT, DONE}, ek)
      `CHK(gm, em)
      if (em) begin
        `CHK({ga, gd, gs}, {ea, ed, es})
      end
      `CHK(gw, ew)
      if (ew) begin
        `CHK({gwi, gwd}, {ewi, ewd})
        rf[ewi] = ewd;
      end
    end
  endtask

  initial begin
    void'($urandom(32'hbef4));
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 0;
    for (int i = 0; i < 15; i++)
      ld(i[3:0], $urandom);
    for (int k = 0; k < 6; k++) begin
      im = k ? $urandom : 8'hff;
      pass_en <= k[0];
      es = (k < 2) ? 3'h4 : k[2:1];
      want(k[0], rf[1] + ((k < 2) ? {im, 2'b0} : 0),
        rf[2] & ((k < 2) ? 32'hffffffff : (k < 4) ? 32'hff : 32'hffff), es, 1, 3, !k[0]);
      run((k < 2) ? {24'he84123, im} : {24'he8c12f, 3'b010, k[2], 4'h3}, 1, 5'b00001);
      `CHK({gma, gms}, {ea, es})
    end
    want(1, rf[4] + 62, rf[5] & 32'hffff, 2, 0, 0, 0);
    run({16'h0, 5'h10, 5'h1f, 3'h4, 3'h5}, 0, 5'b00001);
    want(1, rf[4] + 4095, rf[5] & 32'hffff, 2, 0, 0, 0);
    run({12'hf8a, 4'h4, 4'h5, 12'hfff}, 1, 5'b00001);
    foreach (puw[j]) begin
      im = $urandom;
      off = puw[j][1] ? rf[6] + im : rf[6] - im;
      want(1, puw[j][2] ? off : rf[6], rf[7] & 32'hffff, 2, puw[j][0], 6, off);
      run({12'hf82, 4'h6, 4'h7, 1'b1, puw[j], im}, 1, 5'b00001);
    end
    ld(4'hd, 32'h100);
    SP_LIMIT <= 32'h100;
    want(0, 0, 0, 0, 0, 0, 0);
    run(32'hf82d7d04, 1, 5'b00011);
    want(1, 32'h104, rf[7] & 32'hffff, 2, 1, 13, 32'h104);
    run(32'hf82d7f04, 1, 5'b00001);
    want(1, 32'h104, rf[7] & 32'hffff, 2, 1, 13, 32'h100);
    run(32'hf82d7904, 1, 5'b00001);
    want(0, 0, 0, 0, 0, 0, 0);
    foreach (bad[j])
      run(bad[j], 1, 5'b10000);
    MAIN_EXT <= 0;
    run(32'hf8a45010, 1, 5'b10000);
    run(32'hf8267d04, 1, 5'b10000);
    MAIN_EXT <= 1;
    run(32'hf8267e04, 1, 5'b01000);
    run(32'he841f300, 1, 5'b00100);
    summarize();
  end
endmodule
`default_nettype wire
